// file: rtl/tccu_top.sv
// timer capture/compare unit: prescaler, timer counter, captures,
// compares, compare-one, forced compares and port pin control
// assumes a 16-bit module bus on clk_sys and asynchronous pins
`timescale 1ns/100ps
module tccu_top
  import tccu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // operating modes
  input wire logic freeze_mode,
  input wire logic test_mode,
  // module bus
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [5:0] bus_addr,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  // timer port pins
  input wire logic [7:0] gp_in,
  output logic [7:0] gp_out,
  output logic [7:0] gp_oe,
  // input-only and output-only pins
  input wire logic accumulator_input_pin,
  input wire logic aux_clock_pin,
  output logic pwm_out_a,
  // taps for neighbouring units and interrupt request
  output logic pwm_clk_tick,
  output logic tmr_clk_tick,
  output logic div512_tick,
  output logic irq_req
);
  import tccu_pkg::*;

  // ---- synchronisers: s1 read only by s2
  logic [9:0] s1_q, s2_q, s3_q, filt_q, filt_d1_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
    end else begin
      s1_q <= {aux_clock_pin, accumulator_input_pin, gp_in};
      s2_q <= s1_q;
    end
  end

  // two equal samples needed, so a one-clock glitch never passes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s3_q <= 10'h000;
      filt_q <= 10'h000;
      filt_d1_q <= 10'h000;
    end else begin
      s3_q <= s2_q;
      filt_d1_q <= filt_q;
      for (int i = 0; i < 10; i++)
        if (s2_q[i] == s3_q[i]) filt_q[i] <= s2_q[i];
    end
  end
  logic aux_tick;
  assign aux_tick = filt_q[9] & ~filt_d1_q[9];

  // ---- bus decode
  logic wr, rd;
  assign wr = bus_sel & bus_wr;
  assign rd = bus_sel & ~bus_wr;
  logic frz_tst;
  assign frz_tst = freeze_mode | test_mode;

  function automatic logic [15:0] merge(input logic [15:0] o,
      input logic [15:0] n, input logic [1:0] be);
    merge = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  // compare channel c drives this port bit; fifth shares bit 3
  function automatic logic [2:0] cpin(input int c);
    cpin = (c == OC_N - 1) ? 3'h3 : 3'(c + OC1_PIN);
  endfunction

  // tap select: codes 0..6 divide 2..128, 7 is aux clock
  function automatic logic tap(input logic [2:0] sel,
      input logic [8:0] t, input logic aux);
    tap = (sel == SEL_AUX) ? aux : t[sel];
  endfunction

  // ---- prescaler
  logic [8:0] pres_q;
  logic [8:0] taps;
  always_comb begin
    for (int k = 0; k < 9; k++)
      taps[k] = &(pres_q | ~((9'h002 << k) - 9'h001));
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) pres_q <= PRES_RST;
    else if (wr && hit(bus_addr, OFS_PRES) && freeze_mode)
      pres_q <= 9'(merge({7'h00, pres_q}, bus_wdata, bus_be));
    else pres_q <= pres_q + 9'h001;
  end

  // ---- control registers
  logic [15:0] port_q; // direction high, data low
  logic [5:0] edge_q;
  logic [7:0] mask1_q;
  logic ovf_ie_q, clkout_q, pwmout_q;
  logic [2:0] cap_sel_q, pwm_sel_q;
  logic cap_sel_done_q;
  logic [7:0] c1mask_q, c1data_q;
  logic [9:0] oact_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_q <= 16'h0000;
      edge_q <= 6'h00;
      mask1_q <= 8'h00;
      c1mask_q <= 8'h00;
      c1data_q <= 8'h00;
      oact_q <= 10'h000;
    end else if (wr) begin
      if (hit(bus_addr, OFS_PORT))
        port_q <= merge(port_q, bus_wdata, bus_be);
      if (hit(bus_addr, OFS_EDGE) && bus_be[0])
        edge_q <= bus_wdata[5:0];
      if (hit(bus_addr, OFS_MASK) && bus_be[1])
        mask1_q <= bus_wdata[15:8];
      if (hit(bus_addr, OFS_C1MD)) begin
        if (bus_be[1]) c1mask_q <= bus_wdata[15:8];
        if (bus_be[0]) c1data_q <= bus_wdata[7:0];
      end
      if (hit(bus_addr, OFS_OACT))
        oact_q <= 10'(merge({6'h00, oact_q}, bus_wdata, bus_be));
    end
  end

  // capture select locks after its first write, even one made in freeze/test; freeze/test can still rewrite it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ovf_ie_q <= 1'b0;
      clkout_q <= 1'b0;
      cap_sel_q <= CAP_SEL_RST;
      cap_sel_done_q <= 1'b0;
      pwmout_q <= 1'b0;
      pwm_sel_q <= PWM_SEL_RST;
    end else if (wr) begin
      if (hit(bus_addr, OFS_MASK) && bus_be[0]) begin
        ovf_ie_q <= bus_wdata[OVF_BIT];
        clkout_q <= bus_wdata[CLKOUT_BIT];
        if (!cap_sel_done_q || frz_tst) begin
          cap_sel_q <= bus_wdata[2:0];
          cap_sel_done_q <= 1'b1;
        end
      end
      if (hit(bus_addr, OFS_FRC) && bus_be[0]) begin
        pwmout_q <= bus_wdata[7];
        pwm_sel_q <= bus_wdata[2:0];
      end
    end
  end

  // ---- timer counter
  logic tmr_tick, pwm_tick, timer_count_new_q;
  logic [15:0] timer_count_q;
  logic timer_count_wr;
  assign tmr_tick = tap(cap_sel_q, taps, aux_tick);
  assign pwm_tick = tap(pwm_sel_q, taps, aux_tick);
  assign timer_count_wr = wr && hit(bus_addr, OFS_TIMER_COUNT) && frz_tst;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timer_count_q <= TIMER_COUNT_RST;
      timer_count_new_q <= 1'b0;
    end else begin
      timer_count_new_q <= tmr_tick & ~timer_count_wr;
      if (timer_count_wr) timer_count_q <= merge(timer_count_q, bus_wdata, bus_be);
      else if (tmr_tick) timer_count_q <= timer_count_q + 16'h0001;
    end
  end

  // ---- captures: count sampled before this edge's increment lands
  logic [IC_N-1:0] cap_evt;
  logic [15:0] cap_q [IC_N];
  always_comb begin
    for (int i = 0; i < IC_N; i++) begin
      logic rise, fall;
      rise = filt_q[i] & ~filt_d1_q[i];
      fall = ~filt_q[i] & filt_d1_q[i];
      cap_evt[i] = (edge_q[2*i] & rise) | (edge_q[2*i+1] & fall);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < IC_N; i++) cap_q[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < IC_N; i++)
        if (cap_evt[i]) cap_q[i] <= timer_count_q;
    end
  end

  // ---- compares: only tested on a fresh count and not while the register
  // is being written, so a rewrite in that cycle cannot raise a false match
  logic [15:0] cmp_q [OC_N];
  logic [OC_N-1:0] cmp_wr, match, force_p;
  always_comb begin
    for (int c = 0; c < OC_N; c++) begin
      cmp_wr[c] = wr && hit(bus_addr, 6'(OFS_CMP0 + 2*c));
      match[c] = timer_count_new_q && !cmp_wr[c] && timer_count_q == cmp_q[c];
      force_p[c] = wr && hit(bus_addr, OFS_FRC) && bus_be[1] &&
                   bus_wdata[8+c];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < OC_N; c++) cmp_q[c] <= 16'hFFFF;
    end else begin
      for (int c = 0; c < OC_N; c++)
        if (cmp_wr[c]) cmp_q[c] <= merge(cmp_q[c], bus_wdata, bus_be);
    end
  end

  // ---- compare pin levels; compare-one applied last so it wins
  logic [7:0] lvl_q, owned;
  logic [OC_N-1:0] fire;
  assign fire = match | force_p;
  always_comb begin
    owned = c1mask_q;
    for (int c = 0; c < OC_N; c++)
      if (oact_q[2*c +: 2] != 2'h0) owned[cpin(c)] = 1'b1;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) lvl_q <= 8'h00;
    else begin
      for (int c = 0; c < OC_N; c++)
        if (fire[c])
          case (oact_q[2*c +: 2])
            ACT_TOGGLE: lvl_q[cpin(c)] <= ~lvl_q[cpin(c)];
            ACT_CLEAR: lvl_q[cpin(c)] <= 1'b0;
            ACT_SET: lvl_q[cpin(c)] <= 1'b1;
            default: ;
          endcase
      if (fire[0])
        for (int b = 0; b < 8; b++)
          if (c1mask_q[b]) lvl_q[b] <= c1data_q[b];
    end
  end

  // ---- flags: set wins over clear; clear needs a prior read
  logic [7:0] flag1_q, snap1_q;
  logic ovf_q, snapo_q;
  logic [7:0] set1, clr1;
  logic seto, clro, flag_wr;
  assign set1 = {match, cap_evt};
  assign seto = tmr_tick && !timer_count_wr && timer_count_q == 16'hFFFF;
  assign flag_wr = wr && hit(bus_addr, OFS_FLAG);
  assign clr1 = (flag_wr && bus_be[1]) ? ~bus_wdata[15:8] & snap1_q
                                       : 8'h00;
  assign clro = flag_wr && bus_be[0] && !bus_wdata[OVF_BIT] && snapo_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag1_q <= 8'h00;
      ovf_q <= 1'b0;
    end else begin
      flag1_q <= (flag1_q & ~clr1) | set1;
      ovf_q <= (ovf_q & ~clro) | seto;
    end
  end
  // remember which flags software saw set at its last read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      snap1_q <= 8'h00;
      snapo_q <= 1'b0;
    end else if (rd && hit(bus_addr, OFS_FLAG)) begin
      snap1_q <= flag1_q;
      snapo_q <= ovf_q;
    end else if (flag_wr) begin
      snap1_q <= snap1_q & ~clr1;
      snapo_q <= snapo_q & ~clro;
    end
  end

  // ---- read mux; no read has side effects on counters
  logic [15:0] rmux;
  always_comb begin
    rmux = 16'h0000;
    case (bus_addr)
      OFS_PORT: rmux = {port_q[15:8], s2_q[7:0]};
      OFS_EDGE: rmux = {10'h000, edge_q};
      OFS_MASK: rmux = {mask1_q, ovf_ie_q, clkout_q, 3'h0, cap_sel_q};
      OFS_FLAG: rmux = {flag1_q, ovf_q, 7'h00};
      OFS_TIMER_COUNT: rmux = timer_count_q;
      OFS_PRES: rmux = {7'h00, pres_q};
      OFS_C1MD: rmux = {c1mask_q, c1data_q};
      OFS_FRC: rmux = {8'h00, pwmout_q, 4'h0, pwm_sel_q};
      OFS_ACTL: rmux = {s2_q[8], s2_q[9], 14'h0000};
      OFS_OACT: rmux = {6'h00, oact_q};
      default: begin
        for (int i = 0; i < IC_N; i++)
          if (hit(bus_addr, 6'(OFS_CAP0 + 2*i))) rmux = cap_q[i];
        for (int c = 0; c < OC_N; c++)
          if (hit(bus_addr, 6'(OFS_CMP0 + 2*c))) rmux = cmp_q[c];
      end
    endcase
  end

  // ---- registered outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_sel;
      bus_rdata <= rd ? rmux : 16'h0000;
    end
  end

  // compare-owned pins show their level; others the latched data; clkout_q puts the timer tick on OC1_PIN
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gp_out <= 8'h00;
      gp_oe <= 8'h00;
    end else begin
      gp_oe <= port_q[15:8];
      for (int b = 0; b < 8; b++)
        gp_out[b] <= owned[b] ? lvl_q[b] : port_q[b];
      if (clkout_q) gp_out[OC1_PIN] <= tmr_tick;
    end
  end

  // pwm waveform logic lives elsewhere; this pin only carries the tick
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwm_out_a <= 1'b0;
      pwm_clk_tick <= 1'b0;
      tmr_clk_tick <= 1'b0;
      div512_tick <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      pwm_out_a <= pwmout_q & pwm_tick;
      pwm_clk_tick <= pwm_tick;
      tmr_clk_tick <= tmr_tick;
      div512_tick <= taps[8];
      irq_req <= |(flag1_q & mask1_q) | (ovf_q & ovf_ie_q);
    end
  end

  // ---- checks
  chk_pres_step: assert property (@(posedge clk_sys)
    disable iff (!rst_b) !(wr && hit(bus_addr, OFS_PRES) && freeze_mode)
    |=> pres_q == $past(pres_q) + 9'h001) else $error("prescaler skip");
  chk_cap_sel_lock: assert property (@(posedge clk_sys)
    disable iff (!rst_b) cap_sel_done_q && !frz_tst |=>
    $stable(cap_sel_q)) else $error("capture select rewritten");
  chk_timer_count_advance: assert property (@(posedge clk_sys)
    disable iff (!rst_b) tmr_tick && !timer_count_wr |=>
    timer_count_q == $past(timer_count_q) + 16'h0001) else $error("timer stuck");
  chk_ovf_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seto |=> ovf_q && timer_count_q == 16'h0000) else $error("no overflow");
  chk_cap_latch: assert property (@(posedge clk_sys)
    disable iff (!rst_b) cap_evt[0] |=> cap_q[0] == $past(timer_count_q) &&
    flag1_q[0]) else $error("capture missed");
  chk_irq_level: assert property (@(posedge clk_sys)
    disable iff (!rst_b) |(flag1_q & mask1_q) |=> irq_req) else $error("irq");
  chk_flag_keep: assert property (@(posedge clk_sys)
    disable iff (!rst_b) set1[3] |=> flag1_q[3]) else $error("flag lost");
  chk_force_read: assert property (@(posedge clk_sys)
    disable iff (!rst_b) rd && bus_addr == OFS_FRC |=>
    bus_rdata[15:8] == 8'h00) else $error("force bits read");
  chk_clk_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkout_q && tmr_tick ##1 clkout_q |-> gp_out[OC1_PIN] ##1
    !gp_out[OC1_PIN] || tmr_clk_tick) else $error("clock out");
endmodule

// file: pkg/tccu_pkg.sv
// constants for the timer capture/compare unit
// assumes a 16-bit module bus with byte address and two byte lanes
package tccu_pkg;
  // register byte offsets
  localparam logic [5:0] OFS_PORT = 6'h00;
  localparam logic [5:0] OFS_EDGE = 6'h02;
  localparam logic [5:0] OFS_MASK = 6'h04;
  localparam logic [5:0] OFS_FLAG = 6'h06;
  localparam logic [5:0] OFS_TIMER_COUNT = 6'h08;
  localparam logic [5:0] OFS_PRES = 6'h0A;
  localparam logic [5:0] OFS_C1MD = 6'h0C;
  localparam logic [5:0] OFS_FRC = 6'h0E;
  localparam logic [5:0] OFS_CAP0 = 6'h10;
  localparam logic [5:0] OFS_CMP0 = 6'h16;
  localparam logic [5:0] OFS_ACTL = 6'h20;
  localparam logic [5:0] OFS_OACT = 6'h22;
  // field positions and channel counts
  localparam int OVF_BIT = 7;
  localparam int CLKOUT_BIT = 6;
  localparam int ACC_PIN_BIT = 15;
  localparam int AUX_PIN_BIT = 14;
  localparam int OC1_PIN = 4;
  localparam int IC_N = 3;
  localparam int OC_N = 5;
  // reset values and the aux select code
  localparam logic [2:0] CAP_SEL_RST = 3'h1;
  localparam logic [2:0] PWM_SEL_RST = 3'h0;
  localparam logic [15:0] TIMER_COUNT_RST = 16'h0000;
  localparam logic [8:0] PRES_RST = 9'h000;
  localparam logic [2:0] SEL_AUX = 3'h7;
  // edge select encodings
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // compare pin action encodings
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
endpackage

// file: dv/tccu_bus_host.sv
// processor-side model of the module bus, one access at a time
// assumes the bench clock; requests start on a falling edge
`timescale 1ns/100ps
module tccu_bus_host (
  // clock
  input wire logic clk_sys,
  // module bus
  output logic bus_sel,
  output logic bus_wr,
  output logic [5:0] bus_addr,
  output logic [1:0] bus_be,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);
  // idle bus at time zero
  initial begin
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 6'h00;
    bus_be = 2'h0;
    bus_wdata = 16'h0000;
  end
  // sel lasts one taking edge, since a held sel is a second access;
  // wdata is inverted after use so stale data is never reused
  task automatic xfer(input logic w, input logic [5:0] a,
      input logic [1:0] be, input logic [15:0] d,
      output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    @(negedge clk_sys);
    bus_sel = 1'b1;
    bus_wr = w;
    bus_addr = a;
    bus_be = be;
    bus_wdata = d;
    @(negedge clk_sys);
    bus_sel = 1'b0;
    bus_wdata = ~d;
    // answer is waited for a bounded number of cycles
    for (n = 0; n < 4 && !ok; n++) begin
      if (bus_ack === 1'b1) begin
        ok = 1'b1;
        q = bus_rdata;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask
endmodule

// file: dv/tccu_top_tb_top.sv
// self-checking bench for the timer capture/compare unit
// assumes the bus host model; pins resolve from all drivers
`timescale 1ns/100ps
module tccu_top_tb_top;
  import tccu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b, freeze_mode, test_mode, acc, aux;
  logic bus_sel, bus_wr, bus_ack, pwm_out_a, tmr_clk_tick, irq_req;
  logic [5:0] bus_addr;
  logic [1:0] bus_be;
  logic [15:0] bus_wdata, bus_rdata, q, c;
  logic [7:0] pin_ext, gp_in, gp_out, gp_oe;
  int fail_count = 0;
  int comparisons = 0;
  int np, nt, no, i;
  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  // a pin shows the unit's drive where enabled, else the outside level
  assign gp_in = (gp_oe & gp_out) | (~gp_oe & pin_ext);
  tccu_bus_host tccu_bus_host_i (.clk_sys(clk_sys), .bus_sel(bus_sel),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));
  tccu_top tccu_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .freeze_mode(freeze_mode), .test_mode(test_mode), .bus_sel(bus_sel),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe),
    .accumulator_input_pin(acc), .aux_clock_pin(aux),
    .pwm_out_a(pwm_out_a), .pwm_clk_tick(), .tmr_clk_tick(tmr_clk_tick),
    .div512_tick(), .irq_req(irq_req));
  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a wait that ran out of bound ends the run
  task automatic timeout();
    fail_count++;
    $display("MISMATCH %0t wait ran out", $time);
    end_of_test();
  endtask
  // compare a 16-bit result
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d,
      input logic [1:0] be = 2'h3);
    logic [15:0] r;
    logic ok;
    tccu_bus_host_i.xfer(1'b1, a, be, d, r, ok);
    if (!ok) timeout();
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] r);
    logic ok;
    tccu_bus_host_i.xfer(1'b0, a, 2'h3, 16'h0000, r, ok);
    if (!ok) timeout();
  endtask
  // read a register until one bit is set, bounded
  task automatic poll(input logic [5:0] a, input int b);
    logic [15:0] r;
    int n;
    rd(a, r);
    for (n = 0; n < 80 && r[b] !== 1'b1; n++) rd(a, r);
    if (r[b] !== 1'b1) timeout();
  endtask
  // flag clear sequence: read, then write zero
  task automatic clear_flags();
    rd(OFS_FLAG, q);
    wr(OFS_FLAG, 16'h0000);
    rd(OFS_FLAG, q);
  endtask
  initial begin
    rst_b = 1'b0;
    freeze_mode = 1'b0;
    test_mode = 1'b0;
    pin_ext = 8'h00;
    acc = 1'b0;
    aux = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    // reset state of selects, force bits, prescaler and timer
    rd(OFS_MASK, q);
    chk(q & 16'h0007, {13'h0000, CAP_SEL_RST});
    rd(OFS_FRC, q);
    chk(q & 16'hFF07, {13'h0000, PWM_SEL_RST});
    rd(OFS_PRES, q);
    chk(q & 16'hFE00, 16'h0000);
    rd(OFS_TIMER_COUNT, q);
    chk(16'(q < 16'h0020), 16'h0001);
    // timer write refused outside freeze, taken inside
    wr(OFS_TIMER_COUNT, 16'h8000);
    rd(OFS_TIMER_COUNT, q);
    chk(16'(q < 16'h0040), 16'h0001);
    freeze_mode = 1'b1;
    wr(OFS_TIMER_COUNT, 16'h1234);
    wr(OFS_PRES, 16'h0100);
    rd(OFS_TIMER_COUNT, q);
    chk(16'(q - 16'h1234 < 16'h0004), 16'h0001);
    rd(OFS_PRES, q);
    chk(16'(q[8:0] - 9'h100 < 9'h010), 16'h0001);
    freeze_mode = 1'b0;
    // capture select takes one write; pwm select takes every write
    wr(OFS_MASK, 16'h0002);
    wr(OFS_MASK, 16'h0003);
    rd(OFS_MASK, q);
    chk(q & 16'h0007, 16'h0002);
    wr(OFS_FRC, 16'h0083, 2'h1);
    wr(OFS_FRC, 16'h0081, 2'h1);
    rd(OFS_FRC, q);
    chk(q & 16'h0087, 16'h0081);
    // tick counts over 64 cycles: pwm at div4, timer at div8, and the
    // timer clock also shown on the compare-one pin
    wr(OFS_MASK, 16'h0042);
    np = 0;
    nt = 0;
    no = 0;
    repeat (64) begin
      @(negedge clk_sys);
      np += int'(pwm_out_a);
      nt += int'(tmr_clk_tick);
      no += int'(gp_out[OC1_PIN]);
    end
    chk(16'(np), 16'h0010);
    chk(16'(nt), 16'h0008);
    chk(16'(no), 16'h0008);
    // pin levels and status bits follow the outside
    for (i = 0; i < 2; i++) begin
      pin_ext = 8'hA8 ^ {8{i[0]}};
      acc = i[0];
      aux = !i[0];
      repeat (4) @(negedge clk_sys);
      rd(OFS_PORT, q);
      chk(q & 16'h00FF, {8'h00, pin_ext});
      rd(OFS_ACTL, q);
      chk(q & 16'hC000, {acc, aux, 14'h0000});
    end
    pin_ext = 8'h00;
    repeat (6) @(negedge clk_sys);
    // rising capture on channel one with its interrupt enabled
    wr(OFS_EDGE, {14'h0000, EDGE_RISE});
    wr(OFS_MASK, 16'h0102);
    pin_ext[0] = 1'b1;
    poll(OFS_FLAG, 8);
    chk({15'h0000, irq_req}, 16'h0001);
    rd(OFS_CAP0, c);
    rd(OFS_TIMER_COUNT, q);
    chk(16'(q - c < 16'h0008), 16'h0001);
    pin_ext[0] = 1'b0;
    repeat (40) @(negedge clk_sys);
    rd(OFS_CAP0, q);
    chk(q, c);
    pin_ext[0] = 1'b1;
    repeat (12) @(negedge clk_sys);
    rd(OFS_CAP0, q);
    chk(16'(q != c), 16'h0001);
    clear_flags();
    chk(q & 16'h0100, 16'h0000);
    chk({15'h0000, irq_req}, 16'h0000);
    // a port write that raises the capture pin captures
    wr(OFS_PORT, 16'h0100);
    wr(OFS_PORT, 16'h0101);
    poll(OFS_FLAG, 8);
    wr(OFS_PORT, 16'h0000);
    clear_flags();
    // forced compare two sets its pin without a flag
    wr(OFS_OACT, {12'h000, ACT_SET, 2'h0});
    wr(OFS_PORT, 16'h2000);
    wr(OFS_FRC, 16'h0200, 2'h2);
    repeat (4) @(negedge clk_sys);
    chk({15'h0000, gp_out[5]}, 16'h0001);
    rd(OFS_FLAG, q);
    chk(q & 16'h1000, 16'h0000);
    rd(OFS_FRC, q);
    chk(q & 16'hFF00, 16'h0000);
    // latched port data drives only once the compare lets go
    wr(OFS_PORT, 16'h2000);
    repeat (4) @(negedge clk_sys);
    chk({15'h0000, gp_out[5]}, 16'h0001);
    wr(OFS_OACT, 16'h0000);
    repeat (4) @(negedge clk_sys);
    chk({15'h0000, gp_out[5]}, 16'h0000);
    // compare-one clears the pin that compare two sets in the same cycle
    wr(OFS_C1MD, 16'h2000);
    wr(OFS_OACT, {12'h000, ACT_SET, 2'h0});
    repeat (4) @(negedge clk_sys);
    chk({15'h0000, gp_out[5]}, 16'h0001);
    wr(OFS_FRC, 16'h0300, 2'h2);
    repeat (4) @(negedge clk_sys);
    chk({15'h0000, gp_out[5]}, 16'h0000);
    // wrap from the top sets overflow and requests
    freeze_mode = 1'b1;
    wr(OFS_TIMER_COUNT, 16'hFFF8);
    freeze_mode = 1'b0;
    wr(OFS_MASK, 16'h0080);
    poll(OFS_FLAG, OVF_BIT);
    chk({15'h0000, irq_req}, 16'h0001);
    rd(OFS_FLAG, q);
    chk(q & 16'hF800, 16'hF800);
    clear_flags();
    chk(q & 16'h0080, 16'h0000);
    end_of_test();
  end
endmodule
